// ### ufc_port_pkg.sv
// Shared constants, carriers and helpers of the user flow message port.
// Assumes a single 64-bit lane word per user clock; byte lane 0 is the leftmost byte.
package ufc_port_pkg;

  localparam int DATA_W = 64;
  localparam int KEEP_W = 8;
  localparam int SIZE_W = 8;
  localparam int BEAT_W = 5;
  localparam int BEAT_LSB = 3;
  localparam int FIFO_DEPTH = 32;
  localparam logic [KEEP_W-1:0] KEEP_ALL = 8'hff;
  localparam logic [KEEP_W-1:0] KEEP_NONE = 8'h00;
  localparam logic [2:0] LAST_LANE = 3'h7;
  localparam logic [BEAT_W-1:0] BEATS_NONE = 5'h00;
  localparam logic [BEAT_W-1:0] BEAT_ONE = 5'h01;
  localparam logic [SIZE_W-1:0] SIZE_RESET = 8'h00;

  typedef enum logic [1:0] {LANE_IDLE, LANE_USER, LANE_UFC} lane_kind_type;

  typedef struct packed {
    lane_kind_type kind;
    logic first;
    logic last;
    logic [SIZE_W-1:0] size;
    logic [KEEP_W-1:0] keep;
    logic [DATA_W-1:0] data;
  } lane_word_type;

  typedef struct packed {
    logic valid;
    logic last;
    logic [KEEP_W-1:0] keep;
    logic [DATA_W-1:0] data;
  } user_beat_type;

  typedef struct packed {
    logic valid;
    logic last;
    logic [KEEP_W-1:0] keep;
    logic [DATA_W-1:0] data;
  } rx_frame_type;

  // Leftmost bytes of the final word; keep bit 7 is byte lane 0
  function automatic logic [KEEP_W-1:0] keep_for_size(input logic [SIZE_W-1:0] size);
    keep_for_size = KEEP_ALL << (LAST_LANE - size[2:0]);
  endfunction

  function automatic logic [DATA_W-1:0] byte_mask(input logic [KEEP_W-1:0] keep);
    byte_mask = '0;
    for (int i = 0; i < KEEP_W; i++) begin
      byte_mask[i*8 +: 8] = {8{keep[i]}};
    end
  endfunction

  function automatic logic [BEAT_W-1:0] beats_minus_one(input logic [SIZE_W-1:0] size);
    beats_minus_one = size[SIZE_W-1:BEAT_LSB];
  endfunction

endpackage

// ### ufc_lane_fifo.sv
// Lane-side buffer: first-word-fall-through FIFO with a registered output stage.
// Assumes DEPTH is at least two and both sides run on clk.
`timescale 1ns/100ps
`default_nettype none

module ufc_lane_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic room_two,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);

  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [CNT_W-1:0] count;
    logic out_valid;
    logic [WIDTH-1:0] out_data;
  } fifo_state_type;

  fifo_state_type state_reg;
  fifo_state_type state_next;
  logic push;
  logic pop;
  logic load;

  function automatic logic [PTR_W-1:0] next_ptr(input logic [PTR_W-1:0] p);
    next_ptr = (p == PTR_W'(DEPTH - 1)) ? '0 : p + PTR_W'(1);
  endfunction

  assign in_ready = (state_reg.count != CNT_W'(DEPTH));
  // Two free slots, so a registered ready never overruns the buffer
  assign room_two = (state_reg.count < CNT_W'(DEPTH - 1));
  assign out_valid = state_reg.out_valid;
  assign out_data = state_reg.out_data;
  assign push = in_valid && in_ready;
  assign load = !state_reg.out_valid || out_ready;
  assign pop = load && (state_reg.count != '0);

  always_comb begin
    state_next = state_reg;
    if (load) begin
      state_next.out_valid = pop;
    end
    if (pop) begin
      state_next.out_data = state_reg.mem[state_reg.rd_ptr];
      state_next.rd_ptr = next_ptr(state_reg.rd_ptr);
    end
    if (push) begin
      state_next.mem[state_reg.wr_ptr] = in_data;
      state_next.wr_ptr = next_ptr(state_reg.wr_ptr);
    end
    if (push && !pop) begin
      state_next.count = state_reg.count + CNT_W'(1);
    end else if (pop && !push) begin
      state_next.count = state_reg.count - CNT_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule // ufc_lane_fifo

`default_nettype wire

// ### user_flow_message_port.sv
// User flow message port: message requests, message data, normal data throttle, receive frames.
// Assumes all inputs come from logic on clk; the lane serializer drains lane_tx_word.
// Summary of operation
// - Message ports work only when the block is built with the message option.
// - Request acted on next cycle; waits while an earlier message is not final.
// - Message data is taken within two cycles of acceptance unless higher events.
// - Message ready rises one cycle after the request when nothing higher is pending.
// - Message ready stays high while data for the current message is awaited.
// - Clock compensation, bonding or flow control requests drop message ready.
// - Normal data ready is low whenever message ready is high.
// - A message word moves only on an edge with both valid and ready high.
// - Final word uses only the leftmost bytes needed to finish the message.
// - Valid low while ready is high inserts idle words into the message.
// - Each received message is shown as one frame: data, valid, last, keep.
// - Received valid is high only with valid data; data is ignored otherwise.
// - Received last marks the final word of every incoming message.
// - Received keep gives the valid byte count on the final word.
// - Full duplex has both directions; simplex keeps only its own direction.
// - Normal data is taken only on edges where ready and valid are both high.
`timescale 1ns/100ps
`default_nettype none

module user_flow_message_port #(
  parameter bit UFC_ENABLE = 1'b1,
  parameter bit TX_ENABLE = 1'b1,
  parameter bit RX_ENABLE = 1'b1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic msg_req,
  input wire logic [ufc_port_pkg::SIZE_W-1:0] message_size_minus_one,
  input wire logic [ufc_port_pkg::DATA_W-1:0] ufc_tx_data,
  input wire logic ufc_tx_valid,
  output logic ufc_tx_ready,
  input wire logic clock_compensation_request,
  input wire logic channel_bonding_request,
  input wire logic flow_control_request,
  input wire ufc_port_pkg::user_beat_type user_tx_beat,
  output logic user_tx_ready,
  output ufc_port_pkg::lane_word_type lane_tx_word,
  output logic lane_tx_valid,
  input wire logic lane_tx_ready,
  input wire ufc_port_pkg::lane_word_type lane_rx_word,
  input wire logic lane_rx_valid,
  output logic [ufc_port_pkg::DATA_W-1:0] rx_msg_data,
  output logic rx_msg_valid,
  output logic rx_msg_last,
  output logic [ufc_port_pkg::KEEP_W-1:0] rx_msg_keep
);

  localparam bit TX_ON = UFC_ENABLE && TX_ENABLE;
  localparam bit RX_ON = UFC_ENABLE && RX_ENABLE;

  typedef enum logic {TX_IDLE, TX_SEND} tx_state_type;

  typedef struct packed {
    tx_state_type tx_state;
    logic pend_valid;
    logic [ufc_port_pkg::SIZE_W-1:0] pend_size;
    logic [ufc_port_pkg::SIZE_W-1:0] size;
    logic [ufc_port_pkg::BEAT_W-1:0] beats_left;
    logic first_beat;
    logic ufc_ready;
    logic user_ready;
    logic rx_active;
    logic [ufc_port_pkg::SIZE_W-1:0] rx_size;
    logic [ufc_port_pkg::BEAT_W-1:0] rx_left;
    ufc_port_pkg::rx_frame_type rx;
  } port_state_type;

  port_state_type state_reg;
  port_state_type state_next;
  logic prio;
  logic room;
  logic ufc_take;
  logic final_beat;
  logic req_seen;
  logic [ufc_port_pkg::SIZE_W-1:0] req_size;
  logic accept;
  logic push_valid;
  ufc_port_pkg::lane_word_type push_word;
  logic rx_msg_word;
  logic [ufc_port_pkg::SIZE_W-1:0] rx_cur_size;
  logic [ufc_port_pkg::BEAT_W-1:0] rx_cur_left;

  // Higher priority link events own the lane slot; this block just yields
  assign prio = clock_compensation_request || channel_bonding_request || flow_control_request;

  ufc_lane_fifo #(
    .WIDTH($bits(ufc_port_pkg::lane_word_type)),
    .DEPTH(ufc_port_pkg::FIFO_DEPTH)
  ) lane_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(push_valid),
    .in_data(push_word),
    .in_ready(),
    .room_two(room),
    .out_valid(lane_tx_valid),
    .out_data(lane_tx_word),
    .out_ready(lane_tx_ready)
  );

  assign ufc_take = state_reg.ufc_ready && ufc_tx_valid;
  assign final_beat = ufc_take && (state_reg.beats_left == ufc_port_pkg::BEATS_NONE);
  assign req_seen = msg_req || state_reg.pend_valid;
  assign req_size = state_reg.pend_valid ? state_reg.pend_size : message_size_minus_one;
  // A new message may start on the final word of the one in flight
  assign accept = TX_ON && req_seen && (state_reg.tx_state == TX_IDLE || final_beat);
  assign rx_msg_word = RX_ON && lane_rx_valid && (lane_rx_word.kind == ufc_port_pkg::LANE_UFC)
                       && (lane_rx_word.first || state_reg.rx_active);
  assign rx_cur_size = lane_rx_word.first ? lane_rx_word.size : state_reg.rx_size;
  assign rx_cur_left = lane_rx_word.first ? ufc_port_pkg::beats_minus_one(lane_rx_word.size)
                       : state_reg.rx_left;

  assign ufc_tx_ready = state_reg.ufc_ready;
  assign user_tx_ready = state_reg.user_ready;
  assign rx_msg_data = state_reg.rx.data;
  assign rx_msg_valid = state_reg.rx.valid;
  assign rx_msg_last = state_reg.rx.last;
  assign rx_msg_keep = state_reg.rx.keep;

  always_comb begin
    state_next = state_reg;
    push_valid = 1'b0;
    push_word = '0;
    // Transmit: one lane word per cycle at most
    if (state_reg.ufc_ready) begin
      push_valid = 1'b1;
      if (ufc_tx_valid) begin
        push_word.kind = ufc_port_pkg::LANE_UFC;
        push_word.first = state_reg.first_beat;
        push_word.last = (state_reg.beats_left == ufc_port_pkg::BEATS_NONE);
        push_word.size = state_reg.size;
        push_word.keep = push_word.last ? ufc_port_pkg::keep_for_size(state_reg.size)
                         : ufc_port_pkg::KEEP_ALL;
        push_word.data = ufc_tx_data & ufc_port_pkg::byte_mask(push_word.keep);
        state_next.first_beat = 1'b0;
        if (!push_word.last) begin
          state_next.beats_left = state_reg.beats_left - ufc_port_pkg::BEAT_ONE;
        end
      end else begin
        push_word.kind = ufc_port_pkg::LANE_IDLE;
      end
    end else if (state_reg.user_ready && user_tx_beat.valid) begin
      push_valid = 1'b1;
      push_word.kind = ufc_port_pkg::LANE_USER;
      push_word.last = user_tx_beat.last;
      push_word.keep = user_tx_beat.keep;
      push_word.data = user_tx_beat.data;
    end
    if (final_beat) begin
      state_next.tx_state = TX_IDLE;
    end
    // Only one request is held back; a second one during the wait is dropped
    if (accept) begin
      state_next.pend_valid = 1'b0;
      state_next.tx_state = TX_SEND;
      state_next.size = req_size;
      state_next.beats_left = ufc_port_pkg::beats_minus_one(req_size);
      state_next.first_beat = 1'b1;
    end
    if (TX_ON && msg_req && !accept && !state_reg.pend_valid) begin
      state_next.pend_valid = 1'b1;
      state_next.pend_size = message_size_minus_one;
    end
    // Readies are registered, so they also need two free buffer slots
    state_next.ufc_ready = (state_next.tx_state == TX_SEND) && !prio && room;
    state_next.user_ready = (state_next.tx_state == TX_IDLE) && !prio && room;
    // Receive: frame built from message words, idle words skipped
    state_next.rx.valid = 1'b0;
    state_next.rx.last = 1'b0;
    state_next.rx.keep = ufc_port_pkg::KEEP_NONE;
    if (rx_msg_word) begin
      state_next.rx.valid = 1'b1;
      state_next.rx.data = lane_rx_word.data;
      state_next.rx.last = (rx_cur_left == ufc_port_pkg::BEATS_NONE);
      state_next.rx.keep = state_next.rx.last ? ufc_port_pkg::keep_for_size(rx_cur_size)
                           : ufc_port_pkg::KEEP_ALL;
      state_next.rx_size = rx_cur_size;
      state_next.rx_active = !state_next.rx.last;
      if (!state_next.rx.last) begin
        state_next.rx_left = rx_cur_left - ufc_port_pkg::BEAT_ONE;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  chk_option_gate: assert property (@(posedge clk) disable iff (!rst_n)
    !TX_ON |-> !ufc_tx_ready && !state_reg.pend_valid)
    else $error("message ready without the message option");

  chk_busy_wait: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg.tx_state == TX_SEND && !final_beat && msg_req && !state_reg.pend_valid)
    |=> (state_reg.pend_valid && $stable(state_reg.size)))
    else $error("request not held while message busy");

  chk_ready_two: assert property (@(posedge clk) disable iff (!rst_n)
    (accept ##1 (!prio && room)) |-> ##[0:1] ufc_tx_ready)
    else $error("message ready late after acceptance");

  chk_ready_next: assert property (@(posedge clk) disable iff (!rst_n)
    (accept && !prio && room) |=> ufc_tx_ready && state_reg.first_beat)
    else $error("message ready not one cycle after request");

  chk_ready_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (ufc_tx_ready && !final_beat && !prio && room) |=> ufc_tx_ready)
    else $error("message ready dropped mid message");

  chk_prio_drop: assert property (@(posedge clk) disable iff (!rst_n)
    prio |=> !ufc_tx_ready && !user_tx_ready)
    else $error("ready kept during higher priority request");

  chk_ready_exclusive: assert property (@(posedge clk) disable iff (!rst_n)
    ufc_tx_ready |-> !user_tx_ready)
    else $error("normal ready high with message ready");

  chk_take_push: assert property (@(posedge clk) disable iff (!rst_n)
    (push_valid && push_word.kind == ufc_port_pkg::LANE_UFC) |-> ufc_tx_ready && ufc_tx_valid)
    else $error("message word moved without handshake");

  chk_last_bytes: assert property (@(posedge clk) disable iff (!rst_n)
    (ufc_take && final_beat) |-> push_word.last
    && push_word.keep == ufc_port_pkg::keep_for_size(state_reg.size))
    else $error("final message word keeps wrong bytes");

  chk_idle_fill: assert property (@(posedge clk) disable iff (!rst_n)
    (ufc_tx_ready && !ufc_tx_valid) |-> push_valid && push_word.kind == ufc_port_pkg::LANE_IDLE)
    else $error("no idle word while message data absent");

  chk_rx_follow: assert property (@(posedge clk) disable iff (!rst_n)
    !rx_msg_word |=> !rx_msg_valid)
    else $error("received valid without message word");

  chk_rx_short_msg: assert property (@(posedge clk) disable iff (!rst_n)
    (rx_msg_word && lane_rx_word.first && lane_rx_word.size[7:3] == ufc_port_pkg::BEATS_NONE)
    |=> rx_msg_valid && rx_msg_last && rx_msg_keep == ufc_port_pkg::keep_for_size($past(rx_cur_size)))
    else $error("single word message not marked last");

  chk_size_capture: assert property (@(posedge clk) disable iff (!rst_n)
    accept |=> state_reg.size == $past(req_size) && state_reg.tx_state == TX_SEND)
    else $error("message size not captured at acceptance");

  chk_user_gate: assert property (@(posedge clk) disable iff (!rst_n)
    (push_valid && push_word.kind == ufc_port_pkg::LANE_USER) |-> user_tx_ready && user_tx_beat.valid)
    else $error("normal data taken without handshake");

  chk_req_accept: assert property (@(posedge clk) disable iff (!rst_n)
    (TX_ON && msg_req && state_reg.tx_state == TX_IDLE) |-> accept)
    else $error("request not taken while idle");

  chk_pend_start: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg.pend_valid && final_beat) |=> state_reg.tx_state == TX_SEND && state_reg.first_beat)
    else $error("held request not started");

  chk_pend_keep: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg.pend_valid && msg_req && !accept) |=> $stable(state_reg.pend_size))
    else $error("held size overwritten");

  chk_beats_load: assert property (@(posedge clk) disable iff (!rst_n)
    accept |=> state_reg.beats_left == ufc_port_pkg::beats_minus_one($past(req_size)))
    else $error("word count not taken from size");

  chk_ready_send: assert property (@(posedge clk) disable iff (!rst_n)
    ufc_tx_ready |-> state_reg.tx_state == TX_SEND)
    else $error("message ready with no message");

  chk_user_hold: assert property (@(posedge clk) disable iff (!rst_n)
    ufc_tx_ready |-> !(push_valid && push_word.kind == ufc_port_pkg::LANE_USER))
    else $error("normal word during message");

  chk_first_word: assert property (@(posedge clk) disable iff (!rst_n)
    (ufc_take && state_reg.first_beat) |-> push_word.first)
    else $error("first word not marked");

  chk_full_keep: assert property (@(posedge clk) disable iff (!rst_n)
    (ufc_take && !final_beat) |-> push_word.keep == ufc_port_pkg::KEEP_ALL)
    else $error("inner word not full");

  chk_idle_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (ufc_tx_ready && !ufc_tx_valid) |=> $stable(state_reg.beats_left))
    else $error("idle word counted as data");

  chk_rx_data: assert property (@(posedge clk) disable iff (!rst_n)
    rx_msg_word |=> rx_msg_valid && rx_msg_data == $past(lane_rx_word.data))
    else $error("received word not passed on");

  chk_rx_last_one: assert property (@(posedge clk) disable iff (!rst_n)
    rx_msg_last |-> rx_msg_valid)
    else $error("last without valid");

  chk_rx_keep_full: assert property (@(posedge clk) disable iff (!rst_n)
    (rx_msg_valid && !rx_msg_last) |-> rx_msg_keep == ufc_port_pkg::KEEP_ALL)
    else $error("inner received word not full");

endmodule // user_flow_message_port

`default_nettype wire

// ### ufc_user_app.sv
// User application model: message requests and message words toward the port.
// Assumes its tasks are called at a falling edge of clk.
`timescale 1ns/100ps
`default_nettype none

module ufc_user_app (
  input wire logic clk,
  output logic msg_req,
  output logic [ufc_port_pkg::SIZE_W-1:0] message_size_minus_one,
  output logic [ufc_port_pkg::DATA_W-1:0] ufc_tx_data,
  output logic ufc_tx_valid,
  input wire logic ufc_tx_ready
);
  logic rdy_after_req;
  logic hung;

  initial begin
    msg_req = 1'b0;
    message_size_minus_one = 8'h00;
    ufc_tx_data = 64'h0;
    ufc_tx_valid = 1'b0;
    rdy_after_req = 1'b0;
    hung = 1'b0;
  end

  function automatic logic [63:0] word_of(input int k);
    word_of = 64'h0123456789abcdef ^ {8{8'(k)}};
  endfunction

  // Size is scrambled once the request is gone, so only a captured copy works
  task automatic request(input logic [7:0] sz);
    msg_req = 1'b1;
    message_size_minus_one = sz;
    @(negedge clk);
    msg_req = 1'b0;
    message_size_minus_one = ~sz;
  endtask

  task automatic send(input logic [7:0] sz, input int gap);
    request(sz);
    rdy_after_req = ufc_tx_ready;
    stream(sz, gap);
    ufc_tx_valid = 1'b0;
    ufc_tx_data = ~ufc_tx_data;
  endtask

  // Second request lands mid-message; its words follow with valid kept high
  task automatic send_queued(input logic [7:0] sz_a, input logic [7:0] sz_b);
    request(sz_a);
    fork
      stream(sz_a, 0);
      begin
        @(negedge clk);
        request(sz_b);
      end
    join
    stream(sz_b, 0);
    ufc_tx_valid = 1'b0;
    ufc_tx_data = ~ufc_tx_data;
  endtask

  // Gap idles go before word 1; valid is left as is for a following message
  task automatic stream(input logic [7:0] sz, input int gap);
    int n;
    int k;
    int w;
    n = int'(sz[7:3]) + 1;
    k = 0;
    w = 0;
    while (k < n && w < 600) begin
      ufc_tx_valid = !(k == 1 && gap > 0);
      ufc_tx_data = ufc_tx_valid ? word_of(k) : ~word_of(k);
      if (ufc_tx_valid && ufc_tx_ready) k++;
      else if (ufc_tx_ready) gap--;
      w++;
      @(negedge clk);
    end
    hung = hung | (k < n);
  endtask
endmodule // ufc_user_app

`default_nettype wire

// ### tb_top.sv
// Self-checking bench of the user flow message port.
// Assumes the design's defaults: both directions built, 32-word lane buffer.
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  logic clk;
  logic rst_n;
  logic msg_req;
  logic [7:0] message_size_minus_one;
  logic [63:0] ufc_tx_data;
  logic ufc_tx_valid;
  logic ufc_tx_ready;
  logic [2:0] prio;
  ufc_port_pkg::user_beat_type user_tx_beat;
  logic user_tx_ready;
  ufc_port_pkg::lane_word_type lane_tx_word;
  logic lane_tx_valid;
  logic lane_tx_ready;
  ufc_port_pkg::lane_word_type lane_rx_word;
  logic lane_rx_valid;
  logic [63:0] rx_msg_data;
  logic rx_msg_valid;
  logic rx_msg_last;
  logic [7:0] rx_msg_keep;
  logic rx_only_ready;
  logic rx_only_valid;
  int error_cnt = 0;
  int total_checks = 0;
  ufc_port_pkg::lane_word_type seen[$];

  initial clk = 1'b0;
  always #5 clk = ~clk;

  ufc_user_app u_app (.clk(clk), .msg_req(msg_req), .message_size_minus_one(message_size_minus_one),
    .ufc_tx_data(ufc_tx_data), .ufc_tx_valid(ufc_tx_valid), .ufc_tx_ready(ufc_tx_ready));

  user_flow_message_port u_dut (.clk(clk), .rst_n(rst_n), .msg_req(msg_req),
    .message_size_minus_one(message_size_minus_one), .ufc_tx_data(ufc_tx_data),
    .ufc_tx_valid(ufc_tx_valid), .ufc_tx_ready(ufc_tx_ready), .clock_compensation_request(prio[0]),
    .channel_bonding_request(prio[1]), .flow_control_request(prio[2]), .user_tx_beat(user_tx_beat),
    .user_tx_ready(user_tx_ready), .lane_tx_word(lane_tx_word), .lane_tx_valid(lane_tx_valid),
    .lane_tx_ready(lane_tx_ready), .lane_rx_word(lane_rx_word), .lane_rx_valid(lane_rx_valid),
    .rx_msg_data(rx_msg_data), .rx_msg_valid(rx_msg_valid), .rx_msg_last(rx_msg_last),
    .rx_msg_keep(rx_msg_keep));

  // Receive-only build beside the full one
  user_flow_message_port #(.TX_ENABLE(1'b0)) u_dut_rx (.clk(clk), .rst_n(rst_n), .msg_req(msg_req),
    .message_size_minus_one(message_size_minus_one), .ufc_tx_data(ufc_tx_data), .ufc_tx_valid(ufc_tx_valid),
    .ufc_tx_ready(rx_only_ready), .clock_compensation_request(prio[0]), .channel_bonding_request(prio[1]),
    .flow_control_request(prio[2]), .user_tx_beat(user_tx_beat), .user_tx_ready(), .lane_tx_word(),
    .lane_tx_valid(), .lane_tx_ready(lane_tx_ready), .lane_rx_word(lane_rx_word), .lane_rx_valid(lane_rx_valid),
    .rx_msg_data(), .rx_msg_valid(rx_only_valid), .rx_msg_last(), .rx_msg_keep());

  always @(posedge clk) begin
    if (rst_n && lane_tx_valid && lane_tx_ready) seen.push_back(lane_tx_word);
  end

  always @(negedge clk) begin
    if (ufc_tx_ready === 1'b1) cmp1(user_tx_ready, 1'b0, "normal ready during message");
    if (rst_n === 1'b1) cmp1(rx_only_ready, 1'b0, "message ready in receive-only build");
  end

  task automatic cmp1(input logic got, input logic exp, input string what);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic cmp64(input logic [63:0] got, input logic [63:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  function automatic logic [63:0] mask_of(input logic [7:0] kp);
    for (int i = 0; i < 8; i++) mask_of[i*8 +: 8] = {8{kp[i]}};
  endfunction

  // Bounded wait for lane words; a hang ends the run
  task automatic wait_lane(input int cnt);
    int w;
    w = 0;
    while (seen.size() < cnt && w < 300) begin
      @(negedge clk);
      w++;
    end
    if (seen.size() < cnt || u_app.hung) begin
      cmp1(1'b0, 1'b1, "lane words missing");
      finish_test();
    end
  endtask

  task automatic check_msg(input logic [7:0] sz, input int gap);
    ufc_port_pkg::lane_word_type w;
    int n;
    int k;
    int idles;
    logic [7:0] kp;
    n = int'(sz[7:3]) + 1;
    k = 0;
    idles = 0;
    kp = 8'hff << (3'h7 - sz[2:0]);
    wait_lane(n + gap);
    while (seen.size() > 0 && k < n) begin
      w = seen.pop_front();
      if (w.kind === ufc_port_pkg::LANE_IDLE) begin
        idles++;
      end else begin
        cmp1(w.kind === ufc_port_pkg::LANE_UFC, 1'b1, "message kind");
        cmp1(w.first, k == 0, "first flag");
        cmp1(w.last, k == n - 1, "last flag");
        cmp64(w.data, u_app.word_of(k) & (k == n - 1 ? mask_of(kp) : '1), "message data");
        if (k == n - 1) cmp64(64'(w.keep), 64'(kp), "final keep");
        k++;
      end
    end
    cmp64(64'(idles), 64'(gap), "idle words");
  endtask

  task automatic t_basic();
    u_app.send(8'h09, 1);
    cmp1(u_app.rdy_after_req, 1'b1, "ready one cycle after request");
    check_msg(8'h09, 1);
  endtask

  // A request during a busy message waits and starts on its final word
  task automatic t_queued();
    u_app.send_queued(8'h17, 8'h03);
    check_msg(8'h17, 0);
    check_msg(8'h03, 0);
  endtask

  // Boundary sizes, each back to back with the previous message's drain
  task automatic t_sizes();
    logic [7:0] sz[4] = '{8'h00, 8'h07, 8'h08, 8'hff};
    for (int i = 0; i < 4; i++) begin
      u_app.send(sz[i], 0);
      check_msg(sz[i], 0);
    end
  endtask

  task automatic t_prio();
    for (int i = 0; i < 3; i++) begin
      prio = 3'h1 << i;
      @(negedge clk);
      fork
        u_app.send(8'h10, 0);
        begin
          repeat (3) begin
            @(negedge clk);
            cmp1(ufc_tx_ready, 1'b0, "ready held off by higher event");
          end
          prio = 3'h0;
        end
      join
      check_msg(8'h10, 0);
    end
  endtask

  // Fill the buffer with the lane stalled, then drain with a stuttering lane
  task automatic t_user();
    ufc_port_pkg::lane_word_type w;
    int cnt;
    logic taken;
    cnt = 0;
    taken = 1'b1;
    lane_tx_ready = 1'b0;
    while (taken && cnt < 40) begin
      user_tx_beat = '{valid: 1'b1, last: 1'b1, keep: 8'hff, data: 64'(cnt)};
      taken = user_tx_ready;
      @(negedge clk);
      if (taken) cnt++;
    end
    user_tx_beat = '0;
    cmp1(cnt >= 30 && cnt <= 33, 1'b1, "buffer refuses when full");
    repeat (2 * cnt + 4) begin
      lane_tx_ready = ~lane_tx_ready;
      @(negedge clk);
    end
    lane_tx_ready = 1'b1;
    wait_lane(cnt);
    for (int i = 0; i < cnt; i++) begin
      w = seen.pop_front();
      cmp1(w.kind === ufc_port_pkg::LANE_USER, 1'b1, "user kind");
      cmp64(w.data, 64'(i), "user data in order");
    end
    @(negedge clk);
    cmp1(lane_tx_valid, 1'b0, "buffer empty");
  endtask

  task automatic t_rx();
    logic [7:0] sz;
    logic [7:0] kp;
    int n;
    for (int j = 0; j < 2; j++) begin
      sz = j ? 8'h0a : 8'h00;
      n = int'(sz[7:3]) + 1;
      kp = 8'hff << (3'h7 - sz[2:0]);
      for (int k = 0; k < n; k++) begin
        lane_rx_word = '{kind: ufc_port_pkg::LANE_UFC, first: k == 0, last: k == n - 1, size: sz,
          keep: (k == n - 1) ? kp : 8'hff, data: u_app.word_of(k) & (k == n - 1 ? mask_of(kp) : '1)};
        lane_rx_valid = 1'b1;
        @(negedge clk);
        cmp1(rx_msg_valid, 1'b1, "rx valid");
        cmp1(rx_only_valid, 1'b1, "rx valid in receive-only build");
        cmp1(rx_msg_last, k == n - 1, "rx last");
        cmp64(rx_msg_data, lane_rx_word.data, "rx data");
        if (k == n - 1) cmp64(64'(rx_msg_keep), 64'(kp), "rx keep");
      end
      lane_rx_valid = 1'b0;
      @(negedge clk);
      cmp1(rx_msg_valid, 1'b0, "rx quiet");
    end
    lane_rx_word.first = 1'b0;
    lane_rx_valid = 1'b1;
    @(negedge clk);
    cmp1(rx_msg_valid, 1'b0, "orphan word dropped");
    lane_rx_valid = 1'b0;
    @(negedge clk);
  endtask

  initial begin
    rst_n = 1'b0;
    prio = 3'h0;
    user_tx_beat = '0;
    lane_tx_ready = 1'b1;
    lane_rx_word = '0;
    lane_rx_valid = 1'b0;
    repeat (2) @(negedge clk);
    cmp1(ufc_tx_ready, 1'b0, "ready low in reset");
    rst_n = 1'b1;
    @(negedge clk);
    t_basic();
    $display("done: basic message");
    t_sizes();
    $display("done: message sizes");
    t_queued();
    $display("done: queued request");
    t_prio();
    $display("done: higher events");
    t_user();
    $display("done: normal data");
    t_rx();
    $display("done: receive frames");
    finish_test();
  end
endmodule // tb_top

`default_nettype wire
